// file: logic/vqc_classifier.sv
`timescale 1ns/1ns
`default_nettype none
module vqc_classifier #(
  parameter int RESERVE = vqc_pkg::RESERVE_BUFS
) (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Ingress frame header descriptor
  input wire logic hdr_valid,
  input wire logic [1:0] hdr_src,
  input wire logic hdr_tagged,
  input wire logic [11:0] hdr_vid,
  input wire logic [2:0] hdr_pcp,
  input wire logic [5:0] hdr_tos,
  input wire logic hdr_unicast,
  input wire logic [2:0] hdr_dst_mask,
  input wire logic hdr_vid_known,
  input wire logic [2:0] hdr_vid_members,
  // Classification result
  output logic res_valid,
  output logic res_drop,
  output logic [2:0] res_fwd_mask,
  output logic [1:0] res_class,
  output logic [2:0][1:0] res_queue,
  output logic [15:0] res_tag,
  output logic [2:0] res_ins_mask,
  output logic [2:0] res_rmv_mask,
  // Egress scheduler per port
  input wire logic [2:0][3:0] tx_q_pending,
  input wire logic [2:0] tx_slot,
  output logic [2:0] tx_pick_valid,
  output logic [2:0][1:0] tx_pick_queue,
  // Buffer reservation per port
  output logic [2:0][5:0] reserve_bufs
);
  import vqc_pkg::*;

  initial begin
    if (RESERVE < 1 || RESERVE > 63) begin
      $error("RESERVE must fit six bits");
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [15:0] gctrl2_r, gctrl3_r, prio_map_r, gctrl9_r, status_r;
  logic [15:0] ctrl1_r [NPORT];
  logic [15:0] ctrl2_r [NPORT];
  logic [15:0] tag_r [NPORT];
  logic [15:0] rhi_r [NPORT];
  logic [15:0] rlo_r [NPORT];
  logic [15:0] tos_r [TOS_REGS];
  logic [IDX_W-1:0] idx;
  logic wr_en, rd_hit;
  logic [15:0] rd_val;

  assign idx = paddr[11:2];
  assign wr_en = psel && penable && pwrite && rd_hit;

  // Address decode and read mux shared by reads and error answer
  always_comb begin
    rd_hit = paddr[1:0] == 2'b00;
    rd_val = 16'h0000;
    unique case (idx)
      IDX_GCTRL2: rd_val = gctrl2_r;
      IDX_GCTRL3: rd_val = gctrl3_r;
      IDX_PRIO_MAP: rd_val = prio_map_r;
      IDX_GCTRL9: rd_val = gctrl9_r;
      IDX_STATUS: rd_val = status_r;
      default: begin
        rd_hit = 1'b0;
        for (int p = 0; p < NPORT; p++) begin
          if (idx == IDX_P_CTRL1[p]) begin
            rd_val = ctrl1_r[p];
            rd_hit = 1'b1;
          end
          if (idx == IDX_P_CTRL2[p]) begin
            rd_val = ctrl2_r[p];
            rd_hit = 1'b1;
          end
          if (idx == IDX_P_TAG[p]) begin
            rd_val = tag_r[p];
            rd_hit = 1'b1;
          end
          if (idx == IDX_P_RHI[p]) begin
            rd_val = rhi_r[p];
            rd_hit = 1'b1;
          end
          if (idx == IDX_P_RLO[p]) begin
            rd_val = rlo_r[p];
            rd_hit = 1'b1;
          end
        end
        for (int t = 0; t < TOS_REGS; t++) begin
          if (idx == IDX_TOS_MAP0 + IDX_W'(2 * t)) begin
            rd_val = tos_r[t];
            rd_hit = 1'b1;
          end
        end
        rd_hit = rd_hit && paddr[1:0] == 2'b00;
      end
    endcase
  end

  // Zero wait states; read data captured in setup so it leaves a flop
  assign pready = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {16'h0000, rd_val};
    end
  end

  // Writes take effect in the access phase only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gctrl2_r <= RST_GCTRL2;
      gctrl3_r <= RST_GCTRL3;
      prio_map_r <= RST_PRIO_MAP;
      gctrl9_r <= RST_GCTRL9;
      for (int p = 0; p < NPORT; p++) begin
        ctrl1_r[p] <= RST_P_CTRL1;
        ctrl2_r[p] <= RST_P_CTRL2;
        tag_r[p] <= RST_P_TAG;
        rhi_r[p] <= RST_P_RHI;
        rlo_r[p] <= RST_P_RLO;
      end
      for (int t = 0; t < TOS_REGS; t++) begin
        tos_r[t] <= RST_TOS;
      end
    end else if (wr_en) begin
      if (idx == IDX_GCTRL2) gctrl2_r <= pwdata[15:0];
      if (idx == IDX_GCTRL3) gctrl3_r <= pwdata[15:0];
      if (idx == IDX_PRIO_MAP) prio_map_r <= pwdata[15:0];
      if (idx == IDX_GCTRL9) gctrl9_r <= pwdata[15:0];
      for (int p = 0; p < NPORT; p++) begin
        if (idx == IDX_P_CTRL1[p]) ctrl1_r[p] <= pwdata[15:0];
        if (idx == IDX_P_CTRL2[p]) ctrl2_r[p] <= pwdata[15:0];
        if (idx == IDX_P_TAG[p]) tag_r[p] <= pwdata[15:0];
        if (idx == IDX_P_RHI[p]) rhi_r[p] <= pwdata[15:0];
        if (idx == IDX_P_RLO[p]) rlo_r[p] <= pwdata[15:0];
      end
      for (int t = 0; t < TOS_REGS; t++) begin
        if (idx == IDX_TOS_MAP0 + IDX_W'(2 * t)) tos_r[t] <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Ingress classification
  // ----------------------------------------------------------------
  // Bit of the path-insert field for a source/destination pair
  function automatic int path_bit(input int s, input int d);
    return 2 * s + ((d > s) ? d - 1 : d);
  endfunction

  // Queue field of a two-bit-per-entry table
  function automatic logic [1:0] map2(input logic [127:0] tbl, input logic [5:0] i);
    return tbl[2*i +: 2];
  endfunction

  logic [1:0] src;
  logic vlan_en, vid_null, drop_nxt;
  logic [11:0] pvid, vid_eff;
  logic [2:0] pcp_eff, fwd_nxt, ins_nxt, rmv_nxt;
  logic [1:0] class_nxt;
  logic [2:0][1:0] queue_nxt;
  logic [127:0] tos_flat;

  assign src = (hdr_src > 2'd2) ? 2'd2 : hdr_src;
  assign vlan_en = gctrl2_r[B_VLAN_EN];
  assign pvid = tag_r[src][11:0];
  assign vid_null = hdr_tagged && hdr_vid == 12'h000;

  always_comb begin
    for (int t = 0; t < TOS_REGS; t++) begin
      tos_flat[16*t +: 16] = tos_r[t];
    end
  end

  // Effective VID: untagged frames take the port VID
  always_comb begin
    vid_eff = hdr_tagged ? hdr_vid : pvid;
    if (vid_null && gctrl3_r[B_NULL_VID]) begin
      vid_eff = pvid;
    end
  end

  // Priority ceiling swaps in the port's own user priority
  assign pcp_eff = (hdr_tagged && ctrl2_r[src][B_PRIO_CEIL]) ?
                   tag_r[src][15:13] : hdr_pcp;

  // Forwarding and discard decisions
  always_comb begin
    drop_nxt = hdr_tagged && ctrl1_r[src][B_DROP_TAGGED];
    fwd_nxt = hdr_dst_mask & ctrl2_r[src][2:0];
    if (vlan_en) begin
      if (vid_null && ctrl2_r[src][B_ZERO_VID_DROP]) begin
        drop_nxt = 1'b1;
      end
      if (hdr_tagged && ctrl2_r[src][B_ING_FILTER] && vid_eff != pvid) begin
        drop_nxt = 1'b1;
      end
      if (!hdr_vid_known) begin
        fwd_nxt = fwd_nxt & gctrl9_r[B_INV_FWD_LO +: 3];
      end else begin
        if (gctrl2_r[B_UC_MISMATCH] && hdr_unicast &&
            (hdr_dst_mask & ~hdr_vid_members) != 3'b000) begin
          drop_nxt = 1'b1;
        end
        fwd_nxt = fwd_nxt & hdr_vid_members;
      end
    end
    fwd_nxt[src] = 1'b0;
    if (drop_nxt) begin
      fwd_nxt = 3'b000;
    end
  end

  // Queue class: DiffServ first, then 802.1p, else port-based
  always_comb begin
    if (ctrl1_r[src][B_DSCP_EN]) begin
      class_nxt = map2(tos_flat, hdr_tos);
    end else if (ctrl1_r[src][B_DOT1P_EN] && hdr_tagged) begin
      class_nxt = map2({112'h0, prio_map_r}, {3'b000, pcp_eff});
    end else begin
      class_nxt = ctrl1_r[src][B_PORT_PRIO_LO +: 2];
    end
  end

  // Egress queue count and tag edits per destination
  always_comb begin
    for (int d = 0; d < NPORT; d++) begin
      if (ctrl1_r[d][B_MULTI_Q]) begin
        queue_nxt[d] = class_nxt;
      end else if (ctrl1_r[d][B_TWO_Q]) begin
        queue_nxt[d] = {1'b0, class_nxt[1]};
      end else begin
        queue_nxt[d] = 2'b00;
      end
      ins_nxt[d] = !hdr_tagged && fwd_nxt[d] && (ctrl1_r[d][B_TAG_INS] ||
                   (d != int'(src) && gctrl9_r[path_bit(int'(src), d)]));
      rmv_nxt[d] = hdr_tagged && fwd_nxt[d] && ctrl1_r[d][B_TAG_RMV];
    end
  end

  // Result flops; one cycle after the header
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_drop <= 1'b0;
      res_fwd_mask <= 3'b000;
      res_class <= 2'b00;
      res_queue <= '0;
      res_tag <= 16'h0000;
      res_ins_mask <= 3'b000;
      res_rmv_mask <= 3'b000;
      status_r <= 16'h0000;
    end else begin
      res_valid <= hdr_valid;
      if (hdr_valid) begin
        res_drop <= drop_nxt;
        res_fwd_mask <= fwd_nxt;
        res_class <= class_nxt;
        res_queue <= queue_nxt;
        res_tag <= {pcp_eff, tag_r[src][B_CFI], vid_eff};
        res_ins_mask <= ins_nxt;
        res_rmv_mask <= rmv_nxt;
        // Last result readable by software
        status_r <= {8'h00, drop_nxt, fwd_nxt, class_nxt, src};
      end
    end
  end

  // Reservation only counts while multiple queues are running
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      reserve_bufs[p] = (gctrl2_r[B_BUF_RESERVE] && ctrl1_r[p][B_MULTI_Q]) ?
                        6'(RESERVE) : 6'd0;
    end
  end

  // ----------------------------------------------------------------
  // Egress queue scheduler
  // ----------------------------------------------------------------
  logic [RATIO_W-1:0] credit_r [NPORT][NQUEUE];
  logic [NQUEUE-1:0] strict [NPORT];
  logic [RATIO_W-1:0] ratio [NPORT][NQUEUE];
  logic [1:0] pick [NPORT];
  logic found [NPORT];
  logic reload [NPORT];

  // Highest eligible queue; strict queues are always eligible
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      ratio[p][3] = rhi_r[p][RATIO_W-1:0];
      ratio[p][2] = rhi_r[p][B_RATIO_HI_LO +: RATIO_W];
      ratio[p][1] = rlo_r[p][RATIO_W-1:0];
      ratio[p][0] = rlo_r[p][B_RATIO_HI_LO +: RATIO_W];
      strict[p] = {!rhi_r[p][B_RATIO_CTL], !rhi_r[p][B_RATIO_CTL+8],
                   !rlo_r[p][B_RATIO_CTL], !rlo_r[p][B_RATIO_CTL+8]};
      found[p] = 1'b0;
      pick[p] = 2'd0;
      for (int q = 0; q < NQUEUE; q++) begin
        if (tx_q_pending[p][q] && (strict[p][q] || credit_r[p][q] != '0)) begin
          found[p] = 1'b1;
          pick[p] = 2'(q);
        end
      end
      // Interval ends when pending queues have spent their credit
      reload[p] = !found[p] && tx_q_pending[p] != 4'h0;
      if (reload[p]) begin
        for (int q = 0; q < NQUEUE; q++) begin
          if (tx_q_pending[p][q]) pick[p] = 2'(q);
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < NPORT; p++) begin
        for (int q = 0; q < NQUEUE; q++) begin
          credit_r[p][q] <= '0;
        end
      end
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        if (tx_slot[p] && reload[p]) begin
          for (int q = 0; q < NQUEUE; q++) begin
            credit_r[p][q] <= ratio[p][q];
          end
          if (ratio[p][pick[p]] != '0) begin
            credit_r[p][pick[p]] <= ratio[p][pick[p]] - 1'b1;
          end
        end else if (tx_slot[p] && found[p] && !strict[p][pick[p]]) begin
          credit_r[p][pick[p]] <= credit_r[p][pick[p]] - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pick_valid <= 3'b000;
      tx_pick_queue <= '0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        tx_pick_valid[p] <= tx_slot[p] && tx_q_pending[p] != 4'h0;
        if (tx_slot[p]) tx_pick_queue[p] <= pick[p];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence hdr_s;
    hdr_valid;
  endsequence
  sequence dropped_s;
    res_valid && res_drop && res_fwd_mask == 3'b000;
  endsequence

  drop_tagged_a: assert property (hdr_valid && hdr_tagged &&
    ctrl1_r[src][B_DROP_TAGGED] |=> dropped_s) else $error("tagged frame not dropped");
  vlan_off_a: assert property (hdr_valid && !vlan_en && !hdr_tagged
    |=> res_valid && !res_drop) else $error("drop while VLAN disabled");
  zero_vid_a: assert property (hdr_valid && vlan_en && vid_null &&
    ctrl2_r[src][B_ZERO_VID_DROP] |=> dropped_s) else $error("zero VID frame kept");
  null_vid_a: assert property (hdr_valid && vid_null && gctrl3_r[B_NULL_VID]
    |=> res_tag[11:0] == $past(pvid)) else $error("null VID not replaced");
  ing_filter_a: assert property (hdr_valid && vlan_en && hdr_tagged && !vid_null &&
    ctrl2_r[src][B_ING_FILTER] && hdr_vid != pvid |=> dropped_s)
    else $error("VID mismatch not filtered");
  invalid_vid_a: assert property (hdr_valid && vlan_en && !hdr_vid_known
    |=> (res_fwd_mask & ~$past(gctrl9_r[B_INV_FWD_LO +: 3])) == 3'b000)
    else $error("invalid VID leaked to port");
  member_a: assert property (hdr_s
    |=> (res_fwd_mask & ~$past(ctrl2_r[src][2:0])) == 3'b000)
    else $error("forward outside membership");
  port_prio_a: assert property (hdr_valid && !ctrl1_r[src][B_DSCP_EN] &&
    !ctrl1_r[src][B_DOT1P_EN] |=> res_class == $past(ctrl1_r[src][B_PORT_PRIO_LO +: 2]))
    else $error("port based class wrong");
  strict_top_a: assert property ((tx_slot[0] && tx_q_pending[0][3] && strict[0][3])
    |=> tx_pick_valid[0] && tx_pick_queue[0] == 2'd3) else $error("strict queue passed over");
  apb_err_a: assert property ((psel && !penable && paddr[1:0] != 2'b00)
    ##1 (psel && penable) |-> pslverr) else $error("unaligned access accepted");

endmodule
`default_nettype wire

// file: pkg/vqc_pkg.sv
package vqc_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NPORT = 3;
  localparam int NQUEUE = 4;
  localparam int IDX_W = 10;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_GCTRL2 = 10'h004;
  localparam logic [IDX_W-1:0] IDX_GCTRL3 = 10'h006;
  localparam logic [IDX_W-1:0] IDX_PRIO_MAP = 10'h00c;
  localparam logic [IDX_W-1:0] IDX_TOS_MAP0 = 10'h016;
  localparam logic [IDX_W-1:0] IDX_GCTRL9 = 10'h0ae;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0f0;
  localparam logic [IDX_W-1:0] IDX_P_CTRL1 [NPORT] = '{10'h06c, 10'h084, 10'h09c};
  localparam logic [IDX_W-1:0] IDX_P_CTRL2 [NPORT] = '{10'h06e, 10'h086, 10'h09e};
  localparam logic [IDX_W-1:0] IDX_P_TAG [NPORT] = '{10'h070, 10'h088, 10'h0a0};
  localparam logic [IDX_W-1:0] IDX_P_RHI [NPORT] = '{10'h0c8, 10'h0cc, 10'h0d0};
  localparam logic [IDX_W-1:0] IDX_P_RLO [NPORT] = '{10'h0ca, 10'h0ce, 10'h0d2};
  localparam int TOS_REGS = 8;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_GCTRL2 = 16'h00c0;
  localparam logic [15:0] RST_GCTRL3 = 16'h6300;
  localparam logic [15:0] RST_PRIO_MAP = 16'hfa50;
  localparam logic [15:0] RST_GCTRL9 = 16'h0000;
  localparam logic [15:0] RST_P_CTRL1 = 16'h0000;
  localparam logic [15:0] RST_P_CTRL2 = 16'h0607;
  localparam logic [15:0] RST_P_TAG = 16'h0001;
  localparam logic [15:0] RST_P_RHI = 16'h8488;
  localparam logic [15:0] RST_P_RLO = 16'h8182;
  localparam logic [15:0] RST_TOS = 16'h0000;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int B_VLAN_EN = 15;
  localparam int B_UC_MISMATCH = 7;
  localparam int B_BUF_RESERVE = 0;
  localparam int B_NULL_VID = 3;
  localparam int B_INV_FWD_LO = 8;
  localparam int B_ING_FILTER = 14;
  localparam int B_ZERO_VID_DROP = 13;
  localparam int B_PRIO_CEIL = 3;
  localparam int B_DROP_TAGGED = 9;
  localparam int B_TWO_Q = 8;
  localparam int B_DSCP_EN = 6;
  localparam int B_DOT1P_EN = 5;
  localparam int B_PORT_PRIO_LO = 3;
  localparam int B_TAG_INS = 2;
  localparam int B_TAG_RMV = 1;
  localparam int B_MULTI_Q = 0;
  localparam int B_CFI = 12;
  localparam int B_UPRI_LO = 13;
  localparam int RATIO_W = 7;
  localparam int B_RATIO_CTL = 7;
  localparam int B_RATIO_HI_LO = 8;
  localparam int RESERVE_BUFS = 48;
endpackage

// file: testbench/vqc_egress_model.sv
`timescale 1ns/1ns
`default_nettype none
module vqc_egress_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Grants from the scheduler
  input wire logic [2:0] tx_pick_valid,
  input wire logic [2:0][1:0] tx_pick_queue,
  // Queue occupancy seen by the scheduler
  output logic [2:0][3:0] tx_q_pending
);
  logic [7:0] depth_r [3][4];

  // Bench preloads frames between edges; a poke keeps the model small
  task automatic fill(input int p, input int q, input int n);
    depth_r[p][q] = n[7:0];
  endtask

  // One frame leaves the granted queue; an empty queue never underflows
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 3; i++) begin
        for (int j = 0; j < 4; j++) begin
          depth_r[i][j] <= 8'h00;
        end
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (tx_pick_valid[i] && depth_r[i][tx_pick_queue[i]] != 8'h00) begin
          depth_r[i][tx_pick_queue[i]] <= depth_r[i][tx_pick_queue[i]] - 8'h01;
        end
      end
    end
  end

  // A queue is pending while it holds a frame
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 4; j++) begin
        tx_q_pending[i][j] = (depth_r[i][j] != 8'h00);
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/test_vlan_qos_port_classifier.sv
`timescale 1ns/1ns
`default_nettype none
module test_vlan_qos_port_classifier;
  import vqc_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic hdr_valid, hdr_tagged, hdr_unicast, hdr_vid_known;
  logic [1:0] hdr_src;
  logic [11:0] hdr_vid;
  logic [2:0] hdr_pcp, hdr_dst_mask, hdr_vid_members;
  logic [5:0] hdr_tos;
  logic res_valid, res_drop;
  logic [2:0] res_fwd_mask, res_ins_mask, res_rmv_mask, tx_slot, tx_pick_valid;
  logic [1:0] res_class;
  logic [2:0][1:0] res_queue, tx_pick_queue;
  logic [15:0] res_tag;
  logic [2:0][3:0] tx_q_pending;
  logic [2:0][5:0] reserve_bufs;
  logic uc_v, kn_v;
  int err_total, cmp_count;

  vqc_classifier u_vqc_classifier (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr_src(hdr_src),
    .hdr_tagged(hdr_tagged), .hdr_vid(hdr_vid), .hdr_pcp(hdr_pcp), .hdr_tos(hdr_tos),
    .hdr_unicast(hdr_unicast), .hdr_dst_mask(hdr_dst_mask), .hdr_vid_known(hdr_vid_known),
    .hdr_vid_members(hdr_vid_members), .res_valid(res_valid), .res_drop(res_drop),
    .res_fwd_mask(res_fwd_mask), .res_class(res_class), .res_queue(res_queue),
    .res_tag(res_tag), .res_ins_mask(res_ins_mask), .res_rmv_mask(res_rmv_mask),
    .tx_q_pending(tx_q_pending), .tx_slot(tx_slot), .tx_pick_valid(tx_pick_valid),
    .tx_pick_queue(tx_pick_queue), .reserve_bufs(reserve_bufs));

  vqc_egress_model u_vqc_egress_model (.pclk(pclk), .presetn(presetn),
    .tx_pick_valid(tx_pick_valid), .tx_pick_queue(tx_pick_queue),
    .tx_q_pending(tx_q_pending));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Request held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [15:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    if (n == 64) err_total++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, idx, d, q, e);
  endtask

  task automatic rdc(input string nm, input logic [9:0] idx, input logic [15:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, idx, 16'h0000, q, e);
    chk(nm, x, q[15:0]);
  endtask

  // Header from port 0; answer looked at in its one valid cycle
  task automatic hdr(input logic t, input logic [11:0] v, input logic [2:0] pc,
                     input logic [5:0] ts, input logic [2:0] d, input logic [2:0] m);
    @(posedge pclk);
    hdr_valid <= 1'b1;
    hdr_src <= 2'h0;
    hdr_tagged <= t;
    hdr_vid <= v;
    hdr_pcp <= pc;
    hdr_tos <= ts;
    hdr_unicast <= uc_v;
    hdr_dst_mask <= d;
    hdr_vid_known <= kn_v;
    hdr_vid_members <= m;
    @(posedge pclk);
    hdr_valid <= 1'b0;
    @(negedge pclk);
    chk("res_valid", 16'h0001, 16'(res_valid));
  endtask

  task automatic rc(input logic dr, input logic [2:0] fw);
    chk("res_drop", 16'(dr), 16'(res_drop));
    chk("res_fwd_mask", 16'(fw), 16'(res_fwd_mask));
  endtask

  task automatic pick(input int p, input logic [1:0] q);
    @(posedge pclk);
    tx_slot[p] <= 1'b1;
    @(posedge pclk);
    tx_slot[p] <= 1'b0;
    @(negedge pclk);
    chk("pick_valid", 16'h0001, 16'(tx_pick_valid[p]));
    chk("pick_queue", 16'(q), 16'(tx_pick_queue[p]));
  endtask

  task automatic final_report;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Whole run is well under a thousand cycles; five thousand means a hang
  initial begin
    #200000;
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic e;
    {presetn, psel, penable, pwrite, paddr, pwdata, hdr_valid, hdr_src, hdr_tagged} = '0;
    {hdr_vid, hdr_pcp, hdr_tos, hdr_unicast, hdr_dst_mask, hdr_vid_known} = '0;
    hdr_vid_members = 3'h0;
    tx_slot = 3'h0;
    uc_v = 1'b1;
    kn_v = 1'b1;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and the refused address
    for (int p = 0; p < NPORT; p++) begin
      rdc("p_ctrl1", IDX_P_CTRL1[p], 16'h0000);
      rdc("p_ctrl2", IDX_P_CTRL2[p], 16'h0607);
      rdc("p_tag", IDX_P_TAG[p], 16'h0001);
      rdc("p_rhi", IDX_P_RHI[p], 16'h8488);
      rdc("p_rlo", IDX_P_RLO[p], 16'h8182);
    end
    rdc("gctrl2", IDX_GCTRL2, 16'h00c0);
    rdc("prio_map", IDX_PRIO_MAP, 16'hfa50);
    rdc("gctrl9", IDX_GCTRL9, 16'h0000);
    apb(1'b0, 10'h3ff, 16'h0000, q, e);
    chk("unmapped_err", 16'h0001, 16'(e));
    chk("unmapped_data", 16'h0000, q[15:0]);
    // Unaligned word address refused in the access phase
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= 12'h019;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    chk("unaligned_err", 16'h0001, 16'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    // Port priority, queue count per egress port, buffer reserve
    wr(IDX_P_CTRL1[0], 16'h0018);
    wr(IDX_P_CTRL1[1], 16'h0001);
    wr(IDX_P_CTRL1[2], 16'h0100);
    wr(IDX_GCTRL2, 16'h00c1);
    hdr(1'b0, 12'h001, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b0, 3'h6);
    chk("res_class", 16'h0003, 16'(res_class));
    chk("queue_p1", 16'h0003, 16'(res_queue[1]));
    chk("queue_p2", 16'h0001, 16'(res_queue[2]));
    chk("reserve_p1", 16'h0030, 16'(reserve_bufs[1]));
    chk("reserve_p0", 16'h0000, 16'(reserve_bufs[0]));
    // Every tag through the default map, untagged stays on port priority
    wr(IDX_P_CTRL1[0], 16'h0038);
    for (int t = 0; t < 8; t++) begin
      hdr(1'b1, 12'h001, 3'(t), 6'h00, 3'h6, 3'h7);
      chk("dot1p_class", 16'(t / 2), 16'(res_class));
    end
    hdr(1'b0, 12'h001, 3'h7, 6'h00, 3'h6, 3'h7);
    chk("untagged_class", 16'h0003, 16'(res_class));
    // Class map wins over the tag
    wr(IDX_TOS_MAP0, 16'h000c);
    wr(IDX_P_CTRL1[0], 16'h0060);
    hdr(1'b1, 12'h001, 3'h7, 6'h01, 3'h6, 3'h7);
    chk("tos_class", 16'h0003, 16'(res_class));
    hdr(1'b1, 12'h001, 3'h7, 6'h00, 3'h6, 3'h7);
    chk("tos_class", 16'h0000, 16'(res_class));
    // Tagged frames refused, untagged kept
    wr(IDX_P_CTRL1[0], 16'h0200);
    hdr(1'b1, 12'h001, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b1, 3'h0);
    hdr(1'b0, 12'h001, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b0, 3'h6);
    // Membership narrows forwarding
    wr(IDX_P_CTRL1[0], 16'h0000);
    wr(IDX_P_CTRL2[0], 16'h0602);
    hdr(1'b0, 12'h001, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b0, 3'h2);
    // Ingress filter idle until VLAN enable, then drops a foreign VID
    wr(IDX_P_CTRL2[0], 16'h4607);
    hdr(1'b1, 12'h005, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b0, 3'h6);
    wr(IDX_GCTRL2, 16'h80c0);
    hdr(1'b1, 12'h005, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b1, 3'h0);
    hdr(1'b1, 12'h001, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b0, 3'h6);
    wr(IDX_P_CTRL2[0], 16'h2607);
    hdr(1'b1, 12'h000, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b1, 3'h0);
    // Null VID takes the port VID; ceiling swaps the priority
    wr(IDX_P_CTRL2[0], 16'h0607);
    wr(IDX_GCTRL3, 16'h6308);
    wr(IDX_P_TAG[0], 16'ha123);
    rdc("p_tag", IDX_P_TAG[0], 16'ha123);
    hdr(1'b1, 12'h000, 3'h1, 6'h00, 3'h6, 3'h7);
    chk("tag_vid", 16'h0123, 16'(res_tag[11:0]));
    chk("tag_pcp", 16'h0001, 16'(res_tag[15:13]));
    wr(IDX_P_CTRL2[0], 16'h060f);
    hdr(1'b1, 12'h123, 3'h1, 6'h00, 3'h6, 3'h7);
    chk("tag_pcp", 16'h0005, 16'(res_tag[15:13]));
    chk("res_tag", 16'ha123, res_tag);
    wr(IDX_P_CTRL2[0], 16'h0607);
    // Unicast crossing the VLAN boundary
    hdr(1'b0, 12'h123, 3'h0, 6'h00, 3'h2, 3'h5);
    rc(1'b1, 3'h0);
    hdr(1'b0, 12'h123, 3'h0, 6'h00, 3'h2, 3'h3);
    rc(1'b0, 3'h2);
    // Unknown VID limited by the invalid mask
    uc_v = 1'b0;
    kn_v = 1'b0;
    wr(IDX_GCTRL9, 16'h0400);
    hdr(1'b0, 12'h123, 3'h0, 6'h00, 3'h6, 3'h7);
    rc(1'b0, 3'h4);
    // Insertion by path and by port, removal by port
    kn_v = 1'b1;
    wr(IDX_GCTRL9, 16'h0001);
    wr(IDX_P_CTRL1[2], 16'h0004);
    wr(IDX_P_CTRL1[1], 16'h0002);
    hdr(1'b0, 12'h123, 3'h0, 6'h00, 3'h6, 3'h7);
    chk("ins_mask", 16'h0006, 16'(res_ins_mask));
    chk("rmv_mask", 16'h0000, 16'(res_rmv_mask));
    hdr(1'b1, 12'h123, 3'h0, 6'h00, 3'h6, 3'h7);
    chk("rmv_mask", 16'h0002, 16'(res_rmv_mask));
    chk("ins_mask", 16'h0000, 16'(res_ins_mask));
    // Ratios 8,4,2,1 per interval, then a fresh interval
    for (int j = 0; j < 4; j++) u_vqc_egress_model.fill(0, j, 10);
    for (int i = 0; i < 16; i++) begin
      pick(0, (i < 8 || i == 15) ? 2'h3 : (i < 12) ? 2'h2 : (i < 14) ? 2'h1 : 2'h0);
    end
    // Queues 3 and 2 strict: queue 3 empties, then queue 2 drains fully
    wr(IDX_P_RHI[0], 16'h0408);
    pick(0, 2'h3);
    for (int i = 0; i < 6; i++) pick(0, 2'h2);
    final_report();
  end
endmodule
`default_nettype wire
